// ### dv/lssm_check_monitor.sv
// assertion checker for the link status monitor, bound to its top level
`timescale 1ns/100ps
`include "lssm_consts.svh"
module lssm_check
  import lssm_pkg::*;
#(
  parameter int COUNT_WIDTH = 32
) (
  // clock and reset
  input wire logic                   clk_sys,
  input wire logic                   sys_rst,
  // inputs watched
  input wire lssm_pkg::lssm_mode_type mode,
  input wire logic                   optics_power_low,
  input wire logic                   framer_signal_loss,
  input wire logic                   read_strobe,
  // outputs watched
  input wire logic                   read_valid,
  input wire logic                   receive_alarm_flag,
  input wire logic                   optics_lock_error_flag,
  input wire logic                   optical_power_alarm_flag,
  input wire logic                   signal_loss_flag,
  input wire logic                   out_of_frame_flag,
  input wire logic                   pointer_loss_flag,
  input wire logic                   high_error_rate_flag,
  input wire logic                   local_fault_flag,
  input wire logic                   remote_fault_flag,
  input wire logic [COUNT_WIDTH-1:0] good_packet_count,
  input wire logic [COUNT_WIDTH-1:0] bad_packet_count,
  input wire logic [7:0]             path_signal_label,
  input wire logic                   path_label_is_pos,
  input wire logic                   path_label_is_hdlc
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  read_answer_a: assert property (read_strobe |=> read_valid)
    else $error("read_valid missing after read_strobe");
  read_cause_a: assert property (read_valid |-> $past(read_strobe))
    else $error("read_valid without read_strobe");
  hold_results_a: assert property (!read_valid |-> $stable({signal_loss_flag,
    receive_alarm_flag, good_packet_count}))
    else $error("results changed without a reading");
  alarm_cause_a: assert property (receive_alarm_flag |->
    (optics_lock_error_flag || optical_power_alarm_flag))
    else $error("receive alarm without lock or power flag");
  power_seen_a: assert property (optics_power_low [*8] ##0 read_strobe
    |=> optical_power_alarm_flag)
    else $error("power alarm flag missing");
  sig_loss_a: assert property (framer_signal_loss [*6] ##0 read_strobe
    |=> signal_loss_flag)
    else $error("signal loss flag missing");
  lan_flags_a: assert property (read_valid && mode == LSSM_MODE_LAN |->
    !out_of_frame_flag && !pointer_loss_flag)
    else $error("sonet flag reported in lan mode");
  pos_flags_a: assert property (read_valid && mode == LSSM_MODE_POS |->
    !(high_error_rate_flag || local_fault_flag || remote_fault_flag))
    else $error("ethernet flag reported in sonet mode");
  pos_bad_a: assert property (read_valid && mode == LSSM_MODE_POS |->
    bad_packet_count == '0)
    else $error("bad packets counted in sonet mode");
  label_pos_a: assert property (path_label_is_pos |->
    path_signal_label == `LSSM_LABEL_POS)
    else $error("pos label indication wrong");
  label_hdlc_a: assert property (path_label_is_hdlc |->
    path_signal_label == `LSSM_LABEL_HDLC)
    else $error("hdlc label indication wrong");
endmodule : lssm_check

bind lssm_monitor lssm_check #(.COUNT_WIDTH(COUNT_WIDTH)) chk_u (.clk_sys(clk_sys),
  .sys_rst(sys_rst), .mode(mode), .optics_power_low(optics_power_low),
  .framer_signal_loss(framer_signal_loss), .read_strobe(read_strobe), .read_valid(read_valid),
  .receive_alarm_flag(receive_alarm_flag), .optics_lock_error_flag(optics_lock_error_flag),
  .optical_power_alarm_flag(optical_power_alarm_flag), .signal_loss_flag(signal_loss_flag),
  .out_of_frame_flag(out_of_frame_flag), .pointer_loss_flag(pointer_loss_flag),
  .high_error_rate_flag(high_error_rate_flag), .local_fault_flag(local_fault_flag),
  .remote_fault_flag(remote_fault_flag), .good_packet_count(good_packet_count),
  .bad_packet_count(bad_packet_count), .path_signal_label(path_signal_label),
  .path_label_is_pos(path_label_is_pos), .path_label_is_hdlc(path_label_is_hdlc));

// ### dv/lssm_far_side.sv
// behavioural optics module and framer as seen by the monitor
`timescale 1ns/100ps
module lssm_far_side (
  // framer link side
  output logic       link_clk,
  output logic [8:0] ev,
  output logic [7:0] label,
  // optics and framer status levels
  output logic [9:0] status
);
  initial begin
    link_clk = 1'b0;
    ev = '0;
    label = '0;
    status = '0;
  end
  // one link clock period; strobes change only while the link clock is low
  task automatic pulse(input logic [8:0] e, input logic [7:0] l);
    ev = e;
    label = l;
    #160 link_clk = 1'b1;
    #160 link_clk = 1'b0;
  endtask : pulse
  // link clock stands still between bursts; released lines flip so stale data never passes
  task automatic idle();
    ev = ~ev;
    label = ~label;
  endtask : idle
  task automatic set_status(input logic [9:0] s);
    status = s;
  endtask : set_status
endmodule : lssm_far_side

// ### dv/lssm_monitor_tb.sv
// self-checking testbench for the link status monitor
`timescale 1ns/100ps
module lssm_monitor_tb;
  import lssm_pkg::*;
  typedef struct {logic [10:0] flg; logic [8:0][31:0] cnt; logic [7:0] lbl;} lssm_exp_type;
  logic               clk_sys, sys_rst, read_strobe, read_valid, link_clk, is_pos, is_hdlc;
  lssm_mode_type      mode;
  wire [10:0]         flg;
  wire [8:0][31:0]    cnt;
  logic [8:0]         ev;
  logic [9:0]         status, st;
  logic [7:0]         lbl_in, label;
  logic [31:0]        seed;
  int                 err_total, checks;
  lssm_exp_type       exp_q[$];
  lssm_exp_type       e, got_e;

  lssm_far_side far_u (.link_clk(link_clk), .ev(ev), .label(lbl_in), .status(status));
  lssm_monitor dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .mode(mode),
    .optics_rx_error(status[0]), .optics_lock_error(status[1]), .optics_power_low(status[2]),
    .framer_signal_loss(status[3]), .framer_clock_loss(status[4]),
    .framer_out_of_frame(status[5]), .framer_pointer_loss(status[6]),
    .framer_high_ber(status[7]), .framer_local_fault(status[8]),
    .framer_remote_fault(status[9]), .link_clk(link_clk), .ev_checksum_error(ev[0]),
    .ev_bad_packet(ev[1]), .ev_good_packet(ev[2]), .ev_rx_fifo_error(ev[3]),
    .ev_tx_fifo_error(ev[4]), .ev_section_parity(ev[5]), .ev_line_parity(ev[6]),
    .ev_path_parity(ev[7]), .ev_datapath_parity(ev[8]), .path_label_in(lbl_in),
    .read_strobe(read_strobe), .read_valid(read_valid), .receive_alarm_flag(flg[0]),
    .optics_lock_error_flag(flg[1]), .optical_power_alarm_flag(flg[2]),
    .signal_loss_flag(flg[3]), .clock_loss_flag(flg[4]), .out_of_frame_flag(flg[5]),
    .frame_loss_flag(flg[6]), .pointer_loss_flag(flg[7]), .high_error_rate_flag(flg[8]),
    .local_fault_flag(flg[9]), .remote_fault_flag(flg[10]), .checksum_error_count(cnt[0]),
    .bad_packet_count(cnt[1]), .good_packet_count(cnt[2]), .rx_fifo_error_count(cnt[3]),
    .tx_fifo_error_count(cnt[4]), .section_parity_error_count(cnt[5]),
    .line_parity_error_count(cnt[6]), .path_parity_error_count(cnt[7]),
    .datapath_parity_error_count(cnt[8]), .path_signal_label(label),
    .path_label_is_pos(is_pos), .path_label_is_hdlc(is_hdlc));

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // flags expected from held status levels; frame loss never comes from a brief episode
  function automatic logic [10:0] exp_flags(input logic [9:0] s, input lssm_mode_type md);
    logic sn, et;
    sn = (md == LSSM_MODE_POS) || (md == LSSM_MODE_WAN);
    et = (md == LSSM_MODE_LAN) || (md == LSSM_MODE_WAN);
    return {s[9] & et, s[8] & et, s[7] & et, s[6] & sn, 1'b0, s[5] & sn, s[4:2],
            s[1] | (s[0] & ~s[2]), s[0]};
  endfunction : exp_flags

  task automatic bad(input logic [31:0] ex, input logic [31:0] gt);
    err_total++;
    $display("CHECK FAILED t=%0t exp %h got %h", $time, ex, gt);
  endtask : bad
  task automatic cmp_flags(input logic [10:0] ex, input logic [10:0] gt);
    checks++;
    if (gt !== ex) bad({21'h0, ex}, {21'h0, gt});
  endtask : cmp_flags
  task automatic cmp_count(input logic [31:0] ex, input logic [31:0] gt);
    checks++;
    if (gt !== ex) bad(ex, gt);
  endtask : cmp_count
  task automatic cmp_label(input logic [7:0] ex, input logic [7:0] gt, input logic [1:0] dec);
    checks++;
    if ({gt, dec} !== {ex, ex == 8'h16, ex == 8'hCF}) bad({22'h0, ex, 2'h0}, {22'h0, gt, dec});
  endtask : cmp_label

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick
  // first reading carries ex, any back-to-back ones after it must come back empty
  task automatic do_read(input lssm_exp_type ex, input int n);
    lssm_exp_type z;
    z = ex;
    z.flg = '0;
    z.cnt = '0;
    exp_q.push_back(ex);
    for (int i = 1; i < n; i++) exp_q.push_back(z);
    tick(1);
    read_strobe = 1'b1;
    tick(n);
    read_strobe = 1'b0;
  endtask : do_read

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : stop_test

  // ****************************************************************
  // result watcher
  // ****************************************************************
  always @(negedge clk_sys) begin
    if (read_valid === 1'b1) begin
      if (exp_q.size() == 0) bad(32'h0, 32'h1);
      else begin
        got_e = exp_q.pop_front();
        cmp_flags(got_e.flg, flg);
        for (int i = 0; i < 9; i++) cmp_count(got_e.cnt[i], cnt[i]);
        cmp_label(got_e.lbl, label, {is_pos, is_hdlc});
      end
    end
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    sys_rst = 1'b1;
    read_strobe = 1'b0;
    mode = LSSM_MODE_POS;
    seed = 32'hD193;
    e.cnt = '0;
    e.lbl = 8'h00;
    tick(4);
    sys_rst = 1'b0;
    cmp_flags(11'h000, flg);
    tick(3);
    for (int m = 0; m < 4; m++) begin
      mode = lssm_mode_type'(m);
      for (int p = 0; p < 4; p++) begin
        seed = lfsr(seed);
        // all levels, bare receive error, random levels, then power and framing flags with no signal or clock loss
        st = p == 0 ? 10'h3FF : p == 1 ? 10'h001 : p == 2 ? seed[9:0] : 10'h064;
        far_u.set_status(st);
        e.flg = exp_flags(st, mode);
        tick(10);
        do_read(e, 1);
        far_u.set_status(10'h000);
        tick(4);
        do_read(e, 2);
        tick(2);
      end
    end
    $display("test flags done");
    for (int m = 0; m < 2; m++) begin
      mode = m == 0 ? LSSM_MODE_POS : LSSM_MODE_LAN;
      e.flg = '0;
      e.cnt = '0;
      for (int k = 0; k < 40; k++) begin
        seed = lfsr(seed);
        e.lbl = k < 39 ? seed[23:16] : (m == 0 ? 8'h16 : 8'hCF);
        for (int i = 0; i < 9; i++) e.cnt[i] += seed[i] && !(i == 1 && m == 0);
        far_u.pulse(seed[8:0], e.lbl);
      end
      far_u.idle();
      tick(6);
      do_read(e, 2);
      tick(2);
    end
    $display("test events done");
    far_u.set_status(10'h020);
    e.cnt = '0;
    e.flg = 11'h040;
    tick(75300);
    do_read(e, 1);
    far_u.set_status(10'h000);
    tick(4);
    do_read(e, 2);
    $display("test frame loss done");
    for (int w = 0; w < 20 && exp_q.size() != 0; w++) tick(1);
    if (exp_q.size() != 0) bad(32'h0, exp_q.size());
    stop_test();
  end
endmodule : lssm_monitor_tb

// ### src/lssm_consts.svh
// constants for the link status and statistics monitor
// Behaviour
// - flags are sticky until the next reading
// - receive alarm flag implies lock or power flag
// - optics clock recovery failure sets lock error
// - optics low power (below -30 dBm) sets alarm
// - framer signal loss sets signal loss flag
// - framer clock loss sets clock loss flag
// - out of frame flag in SONET and WAN
// - frame loss after out of frame beyond 3 ms
// - pointer loss flag in SONET and WAN
// - high error rate flag in Ethernet modes
// - local fault flag in Ethernet modes
// - remote fault flag in Ethernet modes
// - count checksum errors since last reading
// - count errored packets in Ethernet modes
// - count good packets since last reading
// - count receive FIFO errors since last reading
// - count transmit FIFO errors since last reading
// - separate section, line, path parity counters
// - expose path signal label octet unchanged
// - count internal data path parity errors
// - flag set depends on operating mode
`ifndef LSSM_CONSTS_SVH
`define LSSM_CONSTS_SVH

// ****************************************************************
// flag positions
// ****************************************************************
`define LSSM_FLAG_RX_ALARM   0
`define LSSM_FLAG_LOCK_ERR   1
`define LSSM_FLAG_POWER      2
`define LSSM_FLAG_SIG_LOSS   3
`define LSSM_FLAG_CLK_LOSS   4
`define LSSM_FLAG_OOF        5
`define LSSM_FLAG_LOF        6
`define LSSM_FLAG_LOP        7
`define LSSM_FLAG_BER        8
`define LSSM_FLAG_LFT        9
`define LSSM_FLAG_RFT        10
`define LSSM_NUM_FLAGS       11

// ****************************************************************
// counter positions
// ****************************************************************
`define LSSM_CNT_CHECKSUM    0
`define LSSM_CNT_BAD_PKT     1
`define LSSM_CNT_GOOD_PKT    2
`define LSSM_CNT_RX_FIFO     3
`define LSSM_CNT_TX_FIFO     4
`define LSSM_CNT_SECTION     5
`define LSSM_CNT_LINE        6
`define LSSM_CNT_PATH        7
`define LSSM_CNT_DATAPATH    8
`define LSSM_NUM_COUNTS      9
`define LSSM_COUNT_WIDTH     32

// ****************************************************************
// timing
// ****************************************************************
`define LSSM_CLK_MHZ         25
`define LSSM_TICK_TIME_US    1
`define LSSM_TICK_CYCLES     (`LSSM_CLK_MHZ * `LSSM_TICK_TIME_US)
`define LSSM_LOF_TIME_MS     3
`define LSSM_LOF_TICKS       ((`LSSM_LOF_TIME_MS * 1000) / `LSSM_TICK_TIME_US)
`define LSSM_TICK_CNT_WIDTH  5
`define LSSM_LOF_CNT_WIDTH   12

// ****************************************************************
// path signal label values
// ****************************************************************
`define LSSM_LABEL_POS       8'h16
`define LSSM_LABEL_HDLC      8'hCF

`endif

// ### src/lssm_event_counter.sv
// read-and-clear saturating event counter
`timescale 1ns/100ps
`include "lssm_consts.svh"

module lssm_event_counter #(
  parameter int WIDTH = `LSSM_COUNT_WIDTH
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  // control
  input  wire logic             count_en,
  input  wire logic             read_clear,
  // result
  output logic [WIDTH-1:0]      count_out
);
  import lssm_pkg::*;

  logic [WIDTH-1:0] acc;

  // saturate rather than wrap so a flood never reads as a small number
  function automatic logic [WIDTH-1:0] sat_inc(input logic [WIDTH-1:0] v);
    sat_inc = (&v) ? v : v + {{(WIDTH-1){1'b0}}, 1'b1};
  endfunction : sat_inc

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      acc <= '0;
    end else if (read_clear) begin
      // an event in the read cycle opens the next interval
      acc <= count_en ? {{(WIDTH-1){1'b0}}, 1'b1} : '0;
    end else if (count_en) begin
      acc <= sat_inc(acc);
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      count_out <= '0;
    end else if (read_clear) begin
      count_out <= acc;
    end
  end

endmodule : lssm_event_counter

// ### src/lssm_monitor.sv
// link status flags and statistics counters, top level
`timescale 1ns/100ps
`include "lssm_consts.svh"

module lssm_monitor #(
  parameter int COUNT_WIDTH = `LSSM_COUNT_WIDTH
) (
  // clock and reset
  input  wire logic                       clk_sys,
  input  wire logic                       sys_rst,
  // configuration
  input  wire lssm_pkg::lssm_mode_type    mode,
  // optics status levels, asynchronous
  input  wire logic                       optics_rx_error,
  input  wire logic                       optics_lock_error,
  input  wire logic                       optics_power_low,
  // framer status levels, asynchronous
  input  wire logic                       framer_signal_loss,
  input  wire logic                       framer_clock_loss,
  input  wire logic                       framer_out_of_frame,
  input  wire logic                       framer_pointer_loss,
  input  wire logic                       framer_high_ber,
  input  wire logic                       framer_local_fault,
  input  wire logic                       framer_remote_fault,
  // framer event strobes, qualified by the link clock
  input  wire logic                       link_clk,
  input  wire logic                       ev_checksum_error,
  input  wire logic                       ev_bad_packet,
  input  wire logic                       ev_good_packet,
  input  wire logic                       ev_rx_fifo_error,
  input  wire logic                       ev_tx_fifo_error,
  input  wire logic                       ev_section_parity,
  input  wire logic                       ev_line_parity,
  input  wire logic                       ev_path_parity,
  input  wire logic                       ev_datapath_parity,
  input  wire logic [7:0]                 path_label_in,
  // host reading
  input  wire logic                       read_strobe,
  output logic                            read_valid,
  // flags
  output logic                            receive_alarm_flag,
  output logic                            optics_lock_error_flag,
  output logic                            optical_power_alarm_flag,
  output logic                            signal_loss_flag,
  output logic                            clock_loss_flag,
  output logic                            out_of_frame_flag,
  output logic                            frame_loss_flag,
  output logic                            pointer_loss_flag,
  output logic                            high_error_rate_flag,
  output logic                            local_fault_flag,
  output logic                            remote_fault_flag,
  // counters
  output logic [COUNT_WIDTH-1:0]          checksum_error_count,
  output logic [COUNT_WIDTH-1:0]          bad_packet_count,
  output logic [COUNT_WIDTH-1:0]          good_packet_count,
  output logic [COUNT_WIDTH-1:0]          rx_fifo_error_count,
  output logic [COUNT_WIDTH-1:0]          tx_fifo_error_count,
  output logic [COUNT_WIDTH-1:0]          section_parity_error_count,
  output logic [COUNT_WIDTH-1:0]          line_parity_error_count,
  output logic [COUNT_WIDTH-1:0]          path_parity_error_count,
  output logic [COUNT_WIDTH-1:0]          datapath_parity_error_count,
  // path signal label
  output logic [7:0]                      path_signal_label,
  output logic                            path_label_is_pos,
  output logic                            path_label_is_hdlc
);
  import lssm_pkg::*;

  localparam int NF = `LSSM_NUM_FLAGS;
  localparam int NC = `LSSM_NUM_COUNTS;
  localparam int NL = 10;

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  logic [NL-1:0] lvl_meta;
  logic [NL-1:0] lvl_sync;
  logic [NC-1:0] ev_meta;
  logic [NC-1:0] ev_sync;
  logic [7:0]    label_meta;
  logic [7:0]    label_sync;
  logic          link_meta;
  logic          link_sync;
  logic          link_prev;
  logic          link_rise;
  logic [NL-1:0] lvl_raw;
  logic [NC-1:0] ev_raw;

  assign lvl_raw = {framer_remote_fault,
                    framer_local_fault,
                    framer_high_ber,
                    framer_pointer_loss,
                    framer_out_of_frame,
                    framer_clock_loss,
                    framer_signal_loss,
                    optics_power_low,
                    optics_lock_error,
                    optics_rx_error};
  assign ev_raw  = {ev_datapath_parity,
                    ev_path_parity,
                    ev_line_parity,
                    ev_section_parity,
                    ev_tx_fifo_error,
                    ev_rx_fifo_error,
                    ev_good_packet,
                    ev_bad_packet,
                    ev_checksum_error};

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      lvl_meta   <= '0;
      lvl_sync   <= '0;
      ev_meta    <= '0;
      ev_sync    <= '0;
      label_meta <= 8'h00;
      label_sync <= 8'h00;
      link_meta  <= 1'b0;
      link_sync  <= 1'b0;
      link_prev  <= 1'b0;
    end else begin
      lvl_meta   <= lvl_raw;
      lvl_sync   <= lvl_meta;
      ev_meta    <= ev_raw;
      ev_sync    <= ev_meta;
      label_meta <= path_label_in;
      label_sync <= label_meta;
      link_meta  <= link_clk;
      link_sync  <= link_meta;
      link_prev  <= link_sync;
    end
  end

  // strobes and label are launched on the falling link edge, so they are
  // settled half a link period before the rising edge that samples them
  // so the label octet needs no gray code
  assign link_rise = link_sync & ~link_prev;

  logic rx_err_s;
  logic lock_err_s;
  logic power_low_s;
  logic sig_loss_s;
  logic clk_loss_s;
  logic oof_s;
  logic lop_s;
  logic ber_s;
  logic lft_s;
  logic rft_s;

  assign rx_err_s    = lvl_sync[0];
  assign lock_err_s  = lvl_sync[1];
  assign power_low_s = lvl_sync[2];
  assign sig_loss_s  = lvl_sync[3];
  assign clk_loss_s  = lvl_sync[4];
  assign oof_s       = lvl_sync[5];
  assign lop_s       = lvl_sync[6];
  assign ber_s       = lvl_sync[7];
  assign lft_s       = lvl_sync[8];
  assign rft_s       = lvl_sync[9];

  // ****************************************************************
  // mode decode
  // ****************************************************************
  logic mode_sonet_frame;
  logic mode_ethernet;

  assign mode_sonet_frame = (mode == LSSM_MODE_POS) || (mode == LSSM_MODE_WAN);
  assign mode_ethernet    = (mode == LSSM_MODE_LAN) || (mode == LSSM_MODE_WAN);

  // ****************************************************************
  // microsecond tick and frame loss timer
  // ****************************************************************
  logic [`LSSM_TICK_CNT_WIDTH-1:0] tick_cnt;
  logic                            us_tick;
  logic [`LSSM_LOF_CNT_WIDTH-1:0]  oof_time;
  logic                            lof_cond;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      tick_cnt <= '0;
      us_tick  <= 1'b0;
    end else if (tick_cnt == `LSSM_TICK_CNT_WIDTH'(`LSSM_TICK_CYCLES - 1)) begin
      tick_cnt <= '0;
      us_tick  <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + `LSSM_TICK_CNT_WIDTH'(1);
      us_tick  <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      oof_time <= '0;
    end else if (!oof_s) begin
      oof_time <= '0;
    end else if (us_tick && !lof_cond) begin
      oof_time <= oof_time + `LSSM_LOF_CNT_WIDTH'(1);
    end
  end

  // strictly more than the limit; the timer holds once past it
  assign lof_cond = oof_time > `LSSM_LOF_CNT_WIDTH'(`LSSM_LOF_TICKS);

  // ****************************************************************
  // flag conditions
  // ****************************************************************
  logic [NF-1:0] flag_cond;

  always_comb begin
    flag_cond = '0;
    flag_cond[`LSSM_FLAG_RX_ALARM] = rx_err_s;
    // lock error, also covers a bare receive error
    flag_cond[`LSSM_FLAG_LOCK_ERR] = lock_err_s | (rx_err_s & ~power_low_s);
    flag_cond[`LSSM_FLAG_POWER]    = power_low_s;
    flag_cond[`LSSM_FLAG_SIG_LOSS] = sig_loss_s;
    flag_cond[`LSSM_FLAG_CLK_LOSS] = clk_loss_s;
    // out of frame in SONET framed modes
    flag_cond[`LSSM_FLAG_OOF]      = oof_s & mode_sonet_frame;
    flag_cond[`LSSM_FLAG_LOF]      = lof_cond;
    // pointer loss in SONET framed modes
    flag_cond[`LSSM_FLAG_LOP]      = lop_s & mode_sonet_frame;
    flag_cond[`LSSM_FLAG_BER]      = ber_s & mode_ethernet;
    flag_cond[`LSSM_FLAG_LFT]      = lft_s & mode_ethernet;
    flag_cond[`LSSM_FLAG_RFT]      = rft_s & mode_ethernet;
  end

  // ****************************************************************
  // sticky flags
  // ****************************************************************
  logic [NF-1:0] flag_sticky;
  logic [NF-1:0] flag_out;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      flag_sticky <= '0;
    end else if (read_strobe) begin
      // a condition present during the read reopens the flag
      flag_sticky <= flag_cond;
    end else begin
      flag_sticky <= flag_sticky | flag_cond;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      flag_out <= '0;
    end else if (read_strobe) begin
      flag_out <= flag_sticky;
    end
  end

  // read_valid leaves on the same edge as the results
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      read_valid <= 1'b0;
    end else begin
      read_valid <= read_strobe;
    end
  end

  assign receive_alarm_flag       = flag_out[`LSSM_FLAG_RX_ALARM];
  assign optics_lock_error_flag   = flag_out[`LSSM_FLAG_LOCK_ERR];
  assign optical_power_alarm_flag = flag_out[`LSSM_FLAG_POWER];
  assign signal_loss_flag         = flag_out[`LSSM_FLAG_SIG_LOSS];
  assign clock_loss_flag          = flag_out[`LSSM_FLAG_CLK_LOSS];
  assign out_of_frame_flag        = flag_out[`LSSM_FLAG_OOF];
  assign frame_loss_flag          = flag_out[`LSSM_FLAG_LOF];
  assign pointer_loss_flag        = flag_out[`LSSM_FLAG_LOP];
  assign high_error_rate_flag     = flag_out[`LSSM_FLAG_BER];
  assign local_fault_flag         = flag_out[`LSSM_FLAG_LFT];
  assign remote_fault_flag        = flag_out[`LSSM_FLAG_RFT];

  // ****************************************************************
  // event counters
  // ****************************************************************
  logic [NC-1:0]          ev_en;
  logic [COUNT_WIDTH-1:0] count_val [NC];

  always_comb begin
    ev_en = ev_sync & {NC{link_rise}};
    // errored packets only counted in Ethernet modes
    ev_en[`LSSM_CNT_BAD_PKT] = ev_sync[`LSSM_CNT_BAD_PKT] & link_rise & mode_ethernet;
  end

  // one counter per event source
  for (genvar i = 0; i < NC; i++) begin : g_count
    lssm_event_counter #(
      .WIDTH      (COUNT_WIDTH)
    ) u_count (
      .clk_sys    (clk_sys),
      .sys_rst    (sys_rst),
      .count_en   (ev_en[i]),
      .read_clear (read_strobe),
      .count_out  (count_val[i])
    );
  end

  assign checksum_error_count        = count_val[`LSSM_CNT_CHECKSUM];
  assign bad_packet_count            = count_val[`LSSM_CNT_BAD_PKT];
  assign good_packet_count           = count_val[`LSSM_CNT_GOOD_PKT];
  assign rx_fifo_error_count         = count_val[`LSSM_CNT_RX_FIFO];
  assign tx_fifo_error_count         = count_val[`LSSM_CNT_TX_FIFO];
  assign section_parity_error_count  = count_val[`LSSM_CNT_SECTION];
  assign line_parity_error_count     = count_val[`LSSM_CNT_LINE];
  assign path_parity_error_count     = count_val[`LSSM_CNT_PATH];
  assign datapath_parity_error_count = count_val[`LSSM_CNT_DATAPATH];

  // ****************************************************************
  // path signal label
  // ****************************************************************
  // label passed through unchanged
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      path_signal_label  <= 8'h00;
      path_label_is_pos  <= 1'b0;
      path_label_is_hdlc <= 1'b0;
    end else if (link_rise) begin
      path_signal_label  <= label_sync;
      path_label_is_pos  <= (label_sync == `LSSM_LABEL_POS);
      path_label_is_hdlc <= (label_sync == `LSSM_LABEL_HDLC);
    end
  end

endmodule : lssm_monitor

// ### src/lssm_pkg.sv
// types for the link status and statistics monitor
package lssm_pkg;

  typedef enum logic [1:0] {
    LSSM_MODE_POS = 2'h0,
    LSSM_MODE_LAN = 2'h1,
    LSSM_MODE_WAN = 2'h2
  } lssm_mode_type;

endpackage : lssm_pkg
